// >>> testbench/testbench.sv
// Self-checking bench for the serial side of the bridge.
// Assumes the peer model on the pins; the bench plays the USB side.
`timescale 1ns/100ps
module testbench;
	localparam int POR = 16;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	usbu_pkg::usbu_cfg_type cfg = '0;
	logic suspend = 1'b0;
	logic suspended;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_par_err;
	logic rx_frame_err;
	logic dtr_req = 1'b0;
	logic rts_req = 1'b0;
	usbu_pkg::usbu_modem_type modem_status;
	logic rx_inverted;
	logic txd;
	logic rxd;
	logic dtr_n;
	logic rts_n;
	logic [3:0] modem_n = 4'hf;
	logic strap = 1'b0;
	int n_errors = 0;
	int checks = 0;
	int rx_n = 0;

	// Clock of 25 ns
	always #12.5 clk = ~clk; // reference clock

	// Count received characters
	always @(posedge clk) if (rx_valid === 1'b1) rx_n <= rx_n + 1;

	usbu_uart #(.POR_CYCLES(POR)) i_dut (.CLK(clk), .NRST(nrst), .CFG(cfg), .SUSPEND(suspend),
		.SUSPENDED(suspended), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_PAR_ERR(rx_par_err), .RX_FRAME_ERR(rx_frame_err),
		.DTR_REQ(dtr_req), .RTS_REQ(rts_req), .MODEM_STATUS(modem_status), .RX_INVERTED(rx_inverted),
		.TXD(txd), .RXD(rxd), .CTS_N(modem_n[3]), .DSR_N(modem_n[2]), .RING_INDICATOR_N(modem_n[1]),
		.CARRIER_DETECT_N(modem_n[0]), .DTR_N(dtr_n), .RTS_N(rts_n), .RX_INVERT_STRAP(strap));
	usbu_peer i_peer (.TXD(txd), .RXD(rxd));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	function automatic logic par_exp(input logic [7:0] d, input logic [1:0] k);
		case (k)
			2'h0: par_exp = ~^d;
			2'h1: par_exp = ^d;
			2'h2: par_exp = 1'b0;
			default: par_exp = 1'b1;
		endcase
	endfunction

	// Called at a rising edge; returns at the edge that takes the byte
	task automatic push(input logic [7:0] d, output int k);
		tx_data <= d;
		tx_valid <= 1'b1;
		k = 0;
		@(negedge clk);
		while (tx_ready !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		// Ready never seen counts as a mismatch
		if (k >= 5000) begin
			n_errors++;
			$display("[ERR] tx_ready expected 1 seen timeout");
		end
		@(posedge clk);
	endtask

	task automatic setfmt(input logic [4:0] r, input logic [1:0] db, input logic pe, input logic [1:0] pk,
		input logic ts, input real b);
		@(posedge clk);
		cfg <= '{r, db, pe, usbu_pkg::usbu_parity_type'(pk), ts};
		i_peer.bit_ns = b;
		i_peer.nbits = 5 + int'(db);
		i_peer.par_en = pe;
		i_peer.two_stop = ts;
		i_peer.got_q.delete();
	endtask

	task automatic wait_peer(input int n);
		int k;
		k = 0;
		while (i_peer.got_q.size() < n && k < 20000) begin
			@(posedge clk);
			k++;
		end
		check("peer_count", n, i_peer.got_q.size());
	endtask

	task automatic do_reset(input logic s);
		int k;
		@(posedge clk);
		nrst <= 1'b0;
		strap <= s;
		repeat (2) @(negedge clk);
		check("txd_in_reset", 1, txd);
		check("dtr_rts_in_reset", 2'h3, {dtr_n, rts_n});
		@(posedge clk);
		nrst <= 1'b1;
		k = 0;
		@(negedge clk);
		while (tx_ready !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		check("por_span", 1, k >= POR - 1 && k <= POR + 4);
		check("txd_idle", 1, txd);
		check("strap_captured", s, rx_inverted);
		@(posedge clk);
		strap <= ~s;
		repeat (8) @(negedge clk);
		check("strap_frozen", s, rx_inverted);
		@(posedge clk);
		strap <= 1'b0;
	endtask

	task automatic t_modem();
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			dtr_req <= k[0];
			rts_req <= k[1];
			modem_n <= ~(4'h8 >> k);
			repeat (5) @(negedge clk);
			check("dtr_rts_n", {!k[0], !k[1]}, {dtr_n, rts_n});
			check("modem_status", 4'h8 >> k, modem_status);
		end
		@(posedge clk);
		modem_n <= 4'hf;
		dtr_req <= 1'b0;
		rts_req <= 1'b0;
	endtask

	task automatic t_tx_fmt();
		logic [7:0] d;
		logic [7:0] m;
		int w;
		for (int k = 0; k < 5; k++) begin
			setfmt(5'h1e, k[1:0], k < 4, k[1:0], k[0], 500.0);
			d = 8'hb6 ^ 8'(k * 37);
			m = 8'hff >> (3 - k % 4);
			push(d, w);
			tx_valid <= 1'b0;
			wait_peer(1);
			check("tx_data", d & m, i_peer.got_q[0]);
			if (k < 4) check("tx_parity", par_exp(d & m, k[1:0]), i_peer.got_par);
			check("tx_stop", 1, i_peer.got_stop);
		end
	endtask

	task automatic t_tx_rate();
		real dt;
		real b;
		int w;
		for (int k = 0; k < 2; k++) begin
			b = k ? 1.0e9 / 115200.0 : 500.0;
			setfmt(k ? 5'h17 : 5'h1e, 2'h3, 1'b0, 2'h0, 1'b0, b);
			push(8'h55, w);
			tx_valid <= 1'b0;
			wait_peer(1);
			check("tx_rate_data", 8'h55, i_peer.got_q[0]);
			dt = i_peer.t_last - i_peer.t_start - 9.0 * b;
			check("tx_period_ok", 1, dt < 9.0 * b * 0.003 + 25.0 && dt > -9.0 * b * 0.003 - 25.0);
		end
	endtask

	task automatic t_burst();
		int w;
		int ref_n;
		ref_n = 0;
		setfmt(5'h1e, 2'h3, 1'b0, 2'h0, 1'b0, 500.0);
		for (int i = 0; i < 12; i++) begin
			push(8'h30 + 8'(i), w);
			if (w > 0) ref_n++;
		end
		tx_valid <= 1'b0;
		check("tx_refused", 1, ref_n > 0);
		wait_peer(12);
		for (int i = 0; i < 12; i++) check("tx_order", 8'h30 + 8'(i), i_peer.got_q[i]);
	endtask

	task automatic t_rx();
		logic [7:0] d;
		int n0;
		for (int k = 0; k < 6; k++) begin
			setfmt(5'h1e, 2'h2, 1'b1, k[1:0], 1'b0, 500.0);
			d = 8'hc3 ^ 8'(k * 21);
			n0 = rx_n;
			i_peer.send(d, k % 2 ? 1.02 : 0.98, par_exp(d & 8'h7f, k[1:0]) ^ (k == 4), k != 5);
			@(negedge clk);
			check("rx_count", n0 + 1, rx_n);
			check("rx_data", d & 8'h7f, rx_data);
			check("rx_par_err", k == 4, rx_par_err);
			check("rx_frame_err", k == 5, rx_frame_err);
		end
	endtask

	task automatic t_suspend();
		int w;
		setfmt(5'h1e, 2'h3, 1'b0, 2'h0, 1'b0, 500.0);
		suspend <= 1'b1;
		repeat (3) @(negedge clk);
		check("suspended", 1, suspended);
		@(posedge clk);
		push(8'h3c, w);
		tx_valid <= 1'b0;
		repeat (400) @(posedge clk);
		check("tx_held", 0, i_peer.got_q.size());
		suspend <= 1'b0;
		wait_peer(1);
		check("tx_resumed", 8'h3c, i_peer.got_q[0]);
		check("suspended_off", 0, suspended);
	endtask

	task automatic t_strap();
		int n0;
		i_peer.set_inv(1'b1);
		do_reset(1'b1);
		setfmt(5'h1e, 2'h3, 1'b0, 2'h0, 1'b0, 500.0);
		n0 = rx_n;
		i_peer.send(8'h96, 1.0, 1'b0, 1'b1);
		@(negedge clk);
		check("rx_inv_count", n0 + 1, rx_n);
		check("rx_inv_data", 8'h96, rx_data);
		i_peer.set_inv(1'b0);
		do_reset(1'b0);
	endtask

	// Main sequence
	initial begin
		do_reset(1'b0);
		t_modem();
		t_tx_fmt();
		t_tx_rate();
		t_burst();
		t_rx();
		t_suspend();
		t_strap();
		stop_test();
	end

	// Watchdog against a hang
	initial begin
		#(40000 * 25);
		n_errors++;
		$display("[ERR] watchdog expected done seen hang");
		stop_test();
	end
endmodule

// >>> testbench/usbu_peer.sv
// Behavioural serial peripheral on the bridge's data pins.
// Assumes the bench sets frame format and bit time before traffic.
`timescale 1ns/100ps
module usbu_peer (
	// Serial lines
	input wire logic TXD,
	output logic RXD
);
	real bit_ns = 500.0;
	int nbits = 8;
	bit par_en = 1'b0;
	bit two_stop = 1'b0;
	bit inv = 1'b0;
	logic [7:0] got_q[$];
	logic got_par;
	logic got_stop;
	realtime t_start;
	realtime t_last;

	// Receive line rests at mark
	initial RXD = 1'b1;

	// Time of latest rising edge
	always @(posedge TXD) t_last = $realtime;

	always @(negedge TXD) begin
		logic [7:0] d;
		d = 8'h00;
		t_start = $realtime;
		#(bit_ns / 2.0);
		for (int i = 0; i < nbits; i++) begin
			#(bit_ns);
			d[i] = TXD;
		end
		if (par_en) begin
			#(bit_ns);
			got_par = TXD;
		end
		#(bit_ns);
		got_stop = TXD;
		if (two_stop) begin
			#(bit_ns);
			got_stop = got_stop & TXD;
		end
		got_q.push_back(d);
	end

	task automatic set_inv(input bit b);
		inv = b;
		RXD = ~b;
	endtask

	task automatic send(input logic [7:0] d, input real f, input logic par, input logic stp);
		real t;
		t = bit_ns * f;
		RXD = inv;
		#(t);
		for (int i = 0; i < nbits; i++) begin
			RXD = d[i] ^ inv;
			#(t);
		end
		if (par_en) begin
			RXD = par ^ inv;
			#(t);
		end
		RXD = stp ^ inv;
		#(t);
		RXD = ~inv;
		#(t);
	endtask
endmodule

// >>> verilog/usbu_defs.svh
// Constants of the serial side of the bridge: timing, sizes, field codes.
// Assumes a 40 MHz system clock and inclusion by its bare name.
//
// Contract
// [RL1] Start bit, five to eight data, parity, stop
// [RL2] Parity odd, even, space or mark
// [RL3] Standard rates from 50 to 2000000 baud
// [RL4] Transmit bit period error below 0.3 percent
// [RL5] Receiver tolerates two percent rate error
// [RL6] Simplex, half or full duplex with FIFO
// [RL7] Drive transmit output, sample receive input
// [RL8] Strap set inverts the receive line
// [RL9] Strap captured during power-on reset only
// [RL10] Strap high asserted, undriven reads low
// [RL11] Modem inputs reported, outputs host driven
// [RL12] Four modem status inputs are provided
// [RL13] Terminal ready and send request outputs
// [RL14] System supplies a 12 MHz reference; the logic here is timed for a 40 MHz clock
// [RL15] Internal power-on reset holds the logic
// [RL16] Suspend reduces activity, resume restores it
// [RL17] Host link is full-speed USB device
// [RL18] Modem pins are low-true
// [RL19] Transmit line idles at mark level
`ifndef USBU_DEFS_SVH
`define USBU_DEFS_SVH

`define USBU_CLK_HZ 40000000
`define USBU_CLK_DIV_MS 1000
`define USBU_POR_MS 20
`define USBU_POR_W 20
`define USBU_FIFO_DEPTH 8
`define USBU_FIFO_AW 3
`define USBU_FIFO_CW 4
`define USBU_OVS 16
`define USBU_OVS_LAST 4'h0f
`define USBU_OVS_MID 4'h07
`define USBU_ACC_W 24
`define USBU_RATE_NUM 31
`define USBU_RATE_LAST 5'h1e
`define USBU_DATA_BASE 3'h4
`define USBU_RATE_SCALE 10
// Rates in tenths of a baud, index is the rate select code
`define USBU_RATE10_LIST '{500, 750, 1000, 1100, 1345, 1500, 3000, 6000, 9000, 12000, 18000, 24000, \
	36000, 48000, 96000, 144000, 192000, 288000, 336000, 384000, 560000, 576000, 768000, 1152000, \
	1280000, 1536000, 2304000, 4608000, 9216000, 15000000, 20000000}

`endif

// >>> verilog/usbu_pkg.sv
// Types shared by the serial side of the bridge.
// Assumes the constants header is compiled alongside.
package usbu_pkg;
	typedef enum logic [1:0] {
		PAR_ODD = 2'h0,
		PAR_EVEN = 2'h1,
		PAR_SPACE = 2'h2,
		PAR_MARK = 2'h3
	} usbu_parity_type;

	// Line settings written by the USB side
	typedef struct packed {
		logic [4:0] rate_sel;
		logic [1:0] data_bits;
		logic parity_en;
		usbu_parity_type parity_kind;
		logic two_stop;
	} usbu_cfg_type;

	// Modem status, active high
	typedef struct packed {
		logic cts;
		logic dsr;
		logic ring;
		logic dcd;
	} usbu_modem_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_PAR = 5'h08,
		ST_STOP = 5'h10
	} usbu_state_type;
endpackage

// >>> verilog/usbu_placeholder_none.sv
// Intentionally empty compile unit.
`timescale 1ns/100ps

// >>> verilog/usbu_uart.sv
// Serial engine of the bridge: transmit FIFO, framer, receiver, modem lines.
// Assumes the USB engine drives the host ports on CLK and the pins are asynchronous.
`timescale 1ns/100ps
`include "usbu_defs.svh"

module usbu_uart #(
	parameter int unsigned POR_CYCLES = `USBU_POR_MS * (`USBU_CLK_HZ / `USBU_CLK_DIV_MS)
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Line settings and power state from the USB side
	input wire usbu_pkg::usbu_cfg_type CFG,
	input wire logic SUSPEND,
	output logic SUSPENDED,
	// Transmit stream from the USB side
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	output logic TX_READY,
	// Receive stream to the USB side
	output logic [7:0] RX_DATA,
	output logic RX_VALID,
	output logic RX_PAR_ERR,
	output logic RX_FRAME_ERR,
	// Modem control from and status to the USB side
	input wire logic DTR_REQ,
	input wire logic RTS_REQ,
	output usbu_pkg::usbu_modem_type MODEM_STATUS,
	output logic RX_INVERTED,
	// Serial pins
	output logic TXD,
	input wire logic RXD,
	input wire logic CTS_N,
	input wire logic DSR_N,
	input wire logic RING_INDICATOR_N,
	input wire logic CARRIER_DETECT_N,
	output logic DTR_N,
	output logic RTS_N,
	input wire logic RX_INVERT_STRAP
);
	localparam logic [`USBU_POR_W-1:0] POR_LAST = `USBU_POR_W'(POR_CYCLES - 1);
	localparam int unsigned RATE10 [0:`USBU_RATE_NUM-1] = `USBU_RATE10_LIST;

	// [RL4] rounded phase step
	// Phase increment giving sixteen ticks per bit at a given rate
	function automatic logic [`USBU_ACC_W-1:0] rate_incr(input int unsigned r10);
		logic [63:0] num;
		logic [63:0] den;
		logic [63:0] q;
		num = (64'(r10) * 64'(`USBU_OVS)) << `USBU_ACC_W;
		den = 64'(`USBU_CLK_HZ) * 64'(`USBU_RATE_SCALE);
		q = (num + (den >> 1)) / den;
		return q[`USBU_ACC_W-1:0];
	endfunction

	// Parity of the significant data bits for the selected kind
	function automatic logic par_of(input logic [7:0] d, input usbu_pkg::usbu_cfg_type c);
		logic [7:0] m;
		m = d & (8'hff >> (2'h3 - c.data_bits));
		case (c.parity_kind)
			usbu_pkg::PAR_ODD: par_of = ~(^m);
			usbu_pkg::PAR_EVEN: par_of = ^m;
			usbu_pkg::PAR_SPACE: par_of = 1'b0;
			default: par_of = 1'b1;
		endcase
	endfunction

	logic [`USBU_POR_W-1:0] por_cnt;
	logic por_done;
	logic [1:0] rxd_s;
	logic [1:0] strap_s;
	logic [3:0] modem_s1;
	logic [3:0] modem_s2;
	logic strap_latch;
	logic [`USBU_ACC_W-1:0] incr_tab [0:`USBU_RATE_NUM-1];
	logic [`USBU_ACC_W-1:0] acc;
	logic tick;
	logic baud_run;
	logic [4:0] sel;
	logic [7:0] fifo_mem [0:`USBU_FIFO_DEPTH-1];
	logic [`USBU_FIFO_AW-1:0] wr_ptr;
	logic [`USBU_FIFO_AW-1:0] rd_ptr;
	logic [`USBU_FIFO_CW-1:0] fifo_cnt;
	logic [`USBU_FIFO_CW-1:0] next_fifo_cnt;
	logic push;
	logic pop;
	usbu_pkg::usbu_state_type tx_state;
	logic [3:0] tx_tcnt;
	logic [7:0] tx_shift;
	logic [2:0] tx_idx;
	logic tx_par;
	logic tx_stop2;
	logic tx_bit_end;
	usbu_pkg::usbu_state_type rx_state;
	logic [3:0] rx_tcnt;
	logic [7:0] rx_shift;
	logic [2:0] rx_idx;
	logic rx_par_err;
	logic rx_bit;
	logic rx_sample;
	logic [2:0] last_idx;

	// Increment table, one constant per supported rate
	genvar g;
	generate
		for (g = 0; g < `USBU_RATE_NUM; g++) begin : g_rate
			assign incr_tab[g] = rate_incr(RATE10[g]);
		end
	endgenerate

	assign last_idx = {1'b0, CFG.data_bits} + `USBU_DATA_BASE;
	assign sel = (CFG.rate_sel > `USBU_RATE_LAST) ? `USBU_RATE_LAST : CFG.rate_sel;
	// [RL8] receive inversion
	assign rx_bit = rxd_s[1] ^ strap_latch;
	assign tx_bit_end = tick && (tx_tcnt == `USBU_OVS_LAST);
	assign rx_sample = tick && (rx_tcnt == ((rx_state == usbu_pkg::ST_START) ? `USBU_OVS_MID : `USBU_OVS_LAST));
	assign push = TX_VALID && TX_READY;
	assign pop = (tx_state == usbu_pkg::ST_IDLE) && tick && (fifo_cnt != '0) && !SUSPENDED && por_done;
	assign next_fifo_cnt = fifo_cnt + `USBU_FIFO_CW'(push) - `USBU_FIFO_CW'(pop);
	// [RL16] baud clock stops while suspended and idle
	assign baud_run = !(SUSPENDED && tx_state == usbu_pkg::ST_IDLE && rx_state == usbu_pkg::ST_IDLE);

	// [RL15] internal power-on reset stretch
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			por_cnt <= '0;
			por_done <= 1'b0;
		end else if (!por_done) begin
			if (por_cnt == POR_LAST) begin
				por_done <= 1'b1;
			end else begin
				por_cnt <= por_cnt + 1'b1;
			end
		end
	end

	// [RL12] modem input synchronisers
	// Pin synchronisers
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rxd_s <= 2'h3;
			// [RL10] strap reads low at rest
			strap_s <= 2'h0;
			modem_s1 <= 4'hf;
			modem_s2 <= 4'hf;
		end else begin
			rxd_s <= {rxd_s[0], RXD};
			strap_s <= {strap_s[0], RX_INVERT_STRAP};
			modem_s1 <= {CTS_N, DSR_N, RING_INDICATOR_N, CARRIER_DETECT_N};
			modem_s2 <= modem_s1;
		end
	end

	// [RL9] strap followed only while in power-on reset
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			strap_latch <= 1'b0;
			RX_INVERTED <= 1'b0;
		end else if (!por_done) begin
			strap_latch <= strap_s[1];
			RX_INVERTED <= strap_s[1];
		end
	end

	// [RL3] fractional rate generator, sixteen ticks per bit
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			acc <= '0;
			tick <= 1'b0;
		end else if (baud_run && por_done) begin
			{tick, acc} <= {1'b0, acc} + {1'b0, incr_tab[sel]};
		end else begin
			tick <= 1'b0;
		end
	end

	// [RL13] [RL18] modem outputs follow host, low-true
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			DTR_N <= 1'b1;
			RTS_N <= 1'b1;
			MODEM_STATUS <= '0;
			SUSPENDED <= 1'b0;
		end else if (por_done) begin
			DTR_N <= ~DTR_REQ;
			RTS_N <= ~RTS_REQ;
			// [RL11] status reported active high
			MODEM_STATUS <= ~modem_s2;
			SUSPENDED <= SUSPEND;
		end
	end

	// [RL6] transmit FIFO with registered ready
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_cnt <= '0;
			TX_READY <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			fifo_cnt <= next_fifo_cnt;
			TX_READY <= por_done && (next_fifo_cnt != `USBU_FIFO_CW'(`USBU_FIFO_DEPTH));
		end
	end

	// FIFO storage
	always_ff @(posedge CLK) begin
		if (push) begin
			fifo_mem[wr_ptr] <= TX_DATA;
		end
	end

	// [RL1] [RL7] transmit framer
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tx_state <= usbu_pkg::ST_IDLE;
			tx_tcnt <= '0;
			tx_shift <= '0;
			tx_idx <= '0;
			tx_par <= 1'b0;
			tx_stop2 <= 1'b0;
			TXD <= 1'b1;
		end else begin
			if (tick) begin
				tx_tcnt <= tx_tcnt + 1'b1;
			end
			case (tx_state)
				usbu_pkg::ST_IDLE: begin
					// [RL19] mark level at rest
					TXD <= 1'b1;
					if (pop) begin
						tx_shift <= fifo_mem[rd_ptr];
						// [RL2] parity generated at load
						tx_par <= par_of(fifo_mem[rd_ptr], CFG);
						tx_tcnt <= '0;
						tx_idx <= '0;
						tx_stop2 <= 1'b0;
						TXD <= 1'b0;
						tx_state <= usbu_pkg::ST_START;
					end
				end
				usbu_pkg::ST_START: begin
					if (tx_bit_end) begin
						TXD <= tx_shift[0];
						tx_state <= usbu_pkg::ST_DATA;
					end
				end
				usbu_pkg::ST_DATA: begin
					if (tx_bit_end) begin
						if (tx_idx == last_idx) begin
							TXD <= CFG.parity_en ? tx_par : 1'b1;
							tx_state <= CFG.parity_en ? usbu_pkg::ST_PAR : usbu_pkg::ST_STOP;
						end else begin
							tx_idx <= tx_idx + 1'b1;
							TXD <= tx_shift[tx_idx + 1'b1];
						end
					end
				end
				usbu_pkg::ST_PAR: begin
					if (tx_bit_end) begin
						TXD <= 1'b1;
						tx_state <= usbu_pkg::ST_STOP;
					end
				end
				usbu_pkg::ST_STOP: begin
					if (tx_bit_end) begin
						if (CFG.two_stop && !tx_stop2) begin
							tx_stop2 <= 1'b1;
						end else begin
							tx_state <= usbu_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					TXD <= 1'b1;
					tx_state <= usbu_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// [RL5] receiver, mid-bit sampling at sixteen ticks per bit
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rx_state <= usbu_pkg::ST_IDLE;
			rx_tcnt <= '0;
			rx_shift <= '0;
			rx_idx <= '0;
			rx_par_err <= 1'b0;
			RX_DATA <= '0;
			RX_VALID <= 1'b0;
			RX_PAR_ERR <= 1'b0;
			RX_FRAME_ERR <= 1'b0;
		end else begin
			RX_VALID <= 1'b0;
			if (tick) begin
				rx_tcnt <= rx_tcnt + 1'b1;
			end
			case (rx_state)
				usbu_pkg::ST_IDLE: begin
					if (por_done && !rx_bit) begin
						rx_tcnt <= '0;
						rx_idx <= '0;
						rx_shift <= '0;
						rx_state <= usbu_pkg::ST_START;
					end
				end
				usbu_pkg::ST_START: begin
					// False start if the line is back high at mid-bit
					if (rx_sample) begin
						rx_tcnt <= '0;
						rx_state <= rx_bit ? usbu_pkg::ST_IDLE : usbu_pkg::ST_DATA;
					end
				end
				usbu_pkg::ST_DATA: begin
					if (rx_sample) begin
						rx_shift[rx_idx] <= rx_bit;
						rx_idx <= rx_idx + 1'b1;
						if (rx_idx == last_idx) begin
							rx_par_err <= 1'b0;
							rx_state <= CFG.parity_en ? usbu_pkg::ST_PAR : usbu_pkg::ST_STOP;
						end
					end
				end
				usbu_pkg::ST_PAR: begin
					// [RL2] parity checked against the selected kind
					if (rx_sample) begin
						rx_par_err <= rx_bit != par_of(rx_shift, CFG);
						rx_state <= usbu_pkg::ST_STOP;
					end
				end
				usbu_pkg::ST_STOP: begin
					if (rx_sample) begin
						RX_DATA <= rx_shift;
						RX_VALID <= 1'b1;
						RX_PAR_ERR <= rx_par_err;
						RX_FRAME_ERR <= !rx_bit;
						rx_state <= usbu_pkg::ST_IDLE;
					end
				end
				default: rx_state <= usbu_pkg::ST_IDLE;
			endcase
		end
	end

	sequence s_tx_launch;
		tx_state == usbu_pkg::ST_IDLE ##1 tx_state == usbu_pkg::ST_START;
	endsequence

	property p_tx_start_low;
		@(posedge CLK) disable iff (!NRST) s_tx_launch |-> !TXD;
	endproperty
	a_tx_start_low: assert property (p_tx_start_low) else $error("start bit not low"); // [RL1]

	property p_tx_idle_mark;
		@(posedge CLK) disable iff (!NRST) (tx_state == usbu_pkg::ST_IDLE && $past(tx_state) == usbu_pkg::ST_IDLE) |-> TXD;
	endproperty
	a_tx_idle_mark: assert property (p_tx_idle_mark) else $error("idle line not at mark"); // [RL19]

	property p_tx_parity;
		@(posedge CLK) disable iff (!NRST) tx_state == usbu_pkg::ST_PAR |-> TXD == tx_par;
	endproperty
	a_tx_parity: assert property (p_tx_parity) else $error("wrong parity bit driven"); // [RL2]

	property p_strap_hold;
		@(posedge CLK) disable iff (!NRST) (por_done && $past(por_done)) |-> $stable(strap_latch);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset"); // [RL9]

	property p_rx_invert;
		@(posedge CLK) disable iff (!NRST)
			(por_done && rx_state == usbu_pkg::ST_IDLE && (rxd_s[1] == strap_latch)) |=> rx_state == usbu_pkg::ST_START;
	endproperty
	a_rx_invert: assert property (p_rx_invert) else $error("start not seen on inverted line"); // [RL8]

	property p_dtr_follow;
		@(posedge CLK) disable iff (!NRST) por_done |=> (DTR_N == !$past(DTR_REQ)) && (RTS_N == !$past(RTS_REQ));
	endproperty
	a_dtr_follow: assert property (p_dtr_follow) else $error("modem output not following host"); // [RL13]

	property p_status_report;
		@(posedge CLK) disable iff (!NRST) $past(por_done) |-> MODEM_STATUS == usbu_pkg::usbu_modem_type'(~$past(modem_s2));
	endproperty
	a_status_report: assert property (p_status_report) else $error("modem status not reported"); // [RL11]

	property p_fifo_full;
		@(posedge CLK) disable iff (!NRST) fifo_cnt == `USBU_FIFO_CW'(`USBU_FIFO_DEPTH) |-> !TX_READY && !push;
	endproperty
	a_fifo_full: assert property (p_fifo_full) else $error("ready while FIFO full"); // [RL6]

	property p_por_hold;
		@(posedge CLK) disable iff (!NRST) !por_done |-> TXD && DTR_N && RTS_N && !TX_READY;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("activity during power-on reset"); // [RL15]

	property p_rx_pulse;
		@(posedge CLK) disable iff (!NRST) RX_VALID |=> !RX_VALID;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("receive valid longer than one cycle"); // [RL7]
endmodule
